// >>> inc/adc_flags_pkg.sv
`default_nettype none
package adc_flags_pkg;
   // Sizes of the converter and of the register window.
   localparam int NCHAN = 8;
   localparam int CHW = 3;
   localparam int RESW = 10;
   localparam int AW = 8;
   localparam int DW = 32;
   localparam int IRQW = 3;
   // Register byte offsets.
   localparam logic [AW-1:0] OFS_CTRL = 8'h00;
   localparam logic [AW-1:0] OFS_MODE = 8'h04;
   localparam logic [AW-1:0] OFS_CHEN = 8'h08;
   localparam logic [AW-1:0] OFS_CHDIS = 8'h0C;
   localparam logic [AW-1:0] OFS_CHSR = 8'h10;
   localparam logic [AW-1:0] OFS_STAT = 8'h14;
   localparam logic [AW-1:0] OFS_LAST = 8'h18;
   localparam logic [AW-1:0] OFS_ISR = 8'h1C;
   localparam logic [AW-1:0] OFS_IMR = 8'h20;
   localparam logic [AW-1:0] OFS_CDR0 = 8'h40;
   localparam logic [AW-1:0] OFS_CDR_END = 8'h60;
   // Field positions.
   localparam int CTRL_START = 0;
   localparam int MODE_SLEEP = 0;
   localparam int STAT_DONE_LSB = 0;
   localparam int STAT_OVR_LSB = 8;
   localparam int STAT_DATA_READY_FLAG = 16;
   localparam int STAT_GLOBAL_OVERRUN_FLAG = 17;
   localparam int LAST_CHAN_LSB = 12;
   localparam int IRQ_STORE = 0;
   localparam int IRQ_OVR = 1;
   localparam int IRQ_SLEEP = 2;
   // Reset values and bus answers.
   localparam logic [NCHAN-1:0] CHEN_RST = 8'h00;
   localparam logic [IRQW-1:0] IMR_RST = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // One end of conversion from the sampling core.
   typedef struct packed {
      logic valid;
      logic [CHW-1:0] chan;
      logic [RESW-1:0] data;
   } conv_evt_t;

   // One register access issued by the bus port.
   typedef struct packed {
      logic valid;
      logic [AW-1:0] addr;
      logic [DW-1:0] data;
   } reg_acc_t;

   // True for an aligned address inside the channel result window.
   function automatic logic is_chan_addr(input logic [AW-1:0] a);
      return (a >= OFS_CDR0) && (a < OFS_CDR_END) && (a[1:0] == 2'h0);
   endfunction

   // Channel number of a channel result address.
   function automatic logic [CHW-1:0] chan_of(input logic [AW-1:0] a);
      logic [AW-1:0] d;
      d = a - OFS_CDR0;
      return d[CHW+1:2];
   endfunction
endpackage
`default_nettype wire

// >>> rtl/result_mem.sv
`timescale 1ns/100ps
`default_nettype none
module result_mem (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic we_i,
   input wire logic [adc_flags_pkg::CHW-1:0] waddr_i,
   input wire logic [adc_flags_pkg::RESW-1:0] wdata_i,
   input wire logic [adc_flags_pkg::CHW-1:0] raddr_i,
   output logic [adc_flags_pkg::RESW-1:0] rdata_o
);
   import adc_flags_pkg::*;

   logic [RESW-1:0] mem [NCHAN];

   // Result storage, one word per channel; cleared so an unused channel reads zero.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < NCHAN; i++) begin
            mem[i] <= '0;
         end
      end else if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
   end

   // Read data always come out of a register, one cycle after the address.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= '0;
      end else begin
         rdata_o <= mem[raddr_i];
      end
   end
endmodule
`default_nettype wire

// >>> rtl/axil_port.sv
`timescale 1ns/100ps
`default_nettype none
module axil_port (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [adc_flags_pkg::AW-1:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [adc_flags_pkg::DW-1:0] wdata_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   input wire logic [adc_flags_pkg::AW-1:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [adc_flags_pkg::DW-1:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   output adc_flags_pkg::reg_acc_t wr_o,
   output adc_flags_pkg::reg_acc_t rd_o,
   input wire logic wr_err_i,
   input wire logic [adc_flags_pkg::DW-1:0] rd_data_i,
   input wire logic rd_err_i
);
   import adc_flags_pkg::*;

   logic aw_held, w_held, rd_pend;
   logic [AW-1:0] aw_addr;
   logic [DW-1:0] w_data;
   logic next_aw_held, next_w_held, next_rd_pend, next_bvalid, next_rvalid;
   logic [AW-1:0] next_aw_addr;
   logic [DW-1:0] next_w_data, next_rdata;
   logic [1:0] next_bresp, next_rresp;

   // Handshakes: one write and one read under way at a time.
   assign awready_o = !aw_held && !bvalid_o;
   assign wready_o = !w_held && !bvalid_o;
   assign arready_o = !rd_pend && !rvalid_o;
   assign wr_o = '{valid: aw_held && w_held && !bvalid_o, addr: aw_addr, data: w_data};
   assign rd_o = '{valid: arvalid_i && arready_o, addr: araddr_i, data: '0};

   // Address and data are caught in either order; the access follows both.
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_bvalid = bvalid_o;
      next_bresp = bresp_o;
      if (awvalid_i && awready_o) begin
         next_aw_held = 1'b1;
         next_aw_addr = awaddr_i;
      end
      if (wvalid_i && wready_o) begin
         next_w_held = 1'b1;
         next_w_data = wdata_i;
      end
      if (wr_o.valid) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = wr_err_i ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_o && bready_i) begin
         next_bvalid = 1'b0;
      end
      next_rd_pend = rd_o.valid;
      next_rvalid = rvalid_o;
      next_rdata = rdata_o;
      next_rresp = rresp_o;
      if (rd_pend) begin
         next_rvalid = 1'b1;
         next_rdata = rd_data_i;
         next_rresp = rd_err_i ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid_o && rready_i) begin
         next_rvalid = 1'b0;
      end
   end

   // Channel state registers.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held <= 1'b0;
         w_data <= '0;
         bvalid_o <= 1'b0;
         bresp_o <= RESP_OKAY;
         rd_pend <= 1'b0;
         rvalid_o <= 1'b0;
         rdata_o <= '0;
         rresp_o <= RESP_OKAY;
      end else begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         bvalid_o <= next_bvalid;
         bresp_o <= next_bresp;
         rd_pend <= next_rd_pend;
         rvalid_o <= next_rvalid;
         rdata_o <= next_rdata;
         rresp_o <= next_rresp;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/adc_result_status_flags.sv
// What this block does
// - Data-ready clears only on a last-result read, never on a channel result read.
// - A channel's done flag clears on its result read or matching last-result read.
// - A channel result read clears only that channel's done flag.
// - End of conversion on enabled channel stores both results and sets data-ready.
// - Data-ready still sets when another channel's result is read that cycle.
// - Status read clears global overrun; a new overrun that cycle wins.
// - Global overrun sets when a conversion on an enabled channel ends while data-ready is active.
// - Disabling a channel does not stop the global overrun of another channel.
// - Channel overrun sets when that channel completes while its done flag stands.
// - Status read resets channel overrun even while its done flag is being set.
// - A channel disabled during its conversion never raises its done flag.
// - Data-ready sets only when new data are really stored.
// - Sleep takes effect only after the next conversion completes.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
module adc_result_status_flags (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [adc_flags_pkg::AW-1:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [adc_flags_pkg::DW-1:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   input wire logic [adc_flags_pkg::AW-1:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [adc_flags_pkg::DW-1:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   input wire adc_flags_pkg::conv_evt_t conv_i,
   output logic start_o,
   output logic sleep_o,
   output logic irq_o
);
   import adc_flags_pkg::*;

   reg_acc_t wr, rd;
   logic [DW-1:0] rd_data;
   logic wr_err, lane0, next_lane0;
   logic [RESW-1:0] mem_q;

   logic [NCHAN-1:0] chan_en, done, ovr;
   logic data_ready_flag, global_overrun_flag, sleep_mode;
   logic [RESW-1:0] last_data;
   logic [CHW-1:0] last_chan;
   logic [IRQW-1:0] isr, imr;
   logic [DW-1:0] rd_reg_q;
   logic rd_chan_q, rd_err_q;

   logic [NCHAN-1:0] next_chan_en, next_done, next_ovr;
   logic next_data_ready_flag, next_global_overrun_flag, next_sleep_mode, next_sleep, next_start;
   logic [RESW-1:0] next_last_data;
   logic [CHW-1:0] next_last_chan;
   logic [IRQW-1:0] next_isr, next_imr, irq_evt;
   logic [DW-1:0] next_rd_reg;
   logic next_rd_chan, next_rd_err;

   logic wr_ctrl, wr_mode, wr_chen, wr_chdis, wr_isr, wr_imr;
   logic rd_chan, rd_last, rd_stat;
   logic [CHW-1:0] rd_idx;
   logic [NCHAN-1:0] dis_mask, en_eff, clr_mask;
   logic eoc_ok, ovr_evt, global_overrun_flag_evt;

   // Bus protocol handling lives in the port; here only decoded accesses.
   axil_port u_port (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .awaddr_i(awaddr_i),
      .awvalid_i(awvalid_i),
      .awready_o(awready_o),
      .wdata_i(wdata_i),
      .wvalid_i(wvalid_i),
      .wready_o(wready_o),
      .bresp_o(bresp_o),
      .bvalid_o(bvalid_o),
      .bready_i(bready_i),
      .araddr_i(araddr_i),
      .arvalid_i(arvalid_i),
      .arready_o(arready_o),
      .rdata_o(rdata_o),
      .rresp_o(rresp_o),
      .rvalid_o(rvalid_o),
      .rready_i(rready_i),
      .wr_o(wr),
      .rd_o(rd),
      .wr_err_i(wr_err),
      .rd_data_i(rd_data),
      .rd_err_i(rd_err_q)
   );

   // Per-channel results, written on every accepted end of conversion.
   result_mem u_mem (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .we_i(eoc_ok),
      .waddr_i(conv_i.chan),
      .wdata_i(conv_i.data),
      .raddr_i(rd_idx),
      .rdata_o(mem_q)
   );

   // Write decode; the low byte lane strobe is caught with the data, since the
   // master may change it once the data handshake is over.
   always_comb begin
      next_lane0 = (wvalid_i && wready_o) ? wstrb_i[0] : lane0;
      wr_ctrl = wr.valid && lane0 && (wr.addr == OFS_CTRL);
      wr_mode = wr.valid && lane0 && (wr.addr == OFS_MODE);
      wr_chen = wr.valid && lane0 && (wr.addr == OFS_CHEN);
      wr_chdis = wr.valid && lane0 && (wr.addr == OFS_CHDIS);
      wr_isr = wr.valid && lane0 && (wr.addr == OFS_ISR);
      wr_imr = wr.valid && lane0 && (wr.addr == OFS_IMR);
      wr_err = !(wr.addr inside {OFS_CTRL, OFS_MODE, OFS_CHEN, OFS_CHDIS, OFS_ISR, OFS_IMR});
   end

   // Read decode; reads with side effects act in the address handshake cycle.
   always_comb begin
      rd_chan = rd.valid && is_chan_addr(rd.addr);
      rd_idx = chan_of(rd.addr);
      rd_last = rd.valid && (rd.addr == OFS_LAST);
      rd_stat = rd.valid && (rd.addr == OFS_STAT);
   end

   // A channel disabled this very cycle already refuses its result.
   always_comb begin
      dis_mask = wr_chdis ? wr.data[NCHAN-1:0] : '0;
      en_eff = chan_en & ~dis_mask;
      eoc_ok = conv_i.valid && en_eff[conv_i.chan];
      ovr_evt = eoc_ok && done[conv_i.chan];
      global_overrun_flag_evt = eoc_ok && data_ready_flag;
   end

   // Flag update; in every flag a coincident set overrides the clear.
   always_comb begin
      next_chan_en = (chan_en | (wr_chen ? wr.data[NCHAN-1:0] : '0)) & ~dis_mask;
      clr_mask = '0;
      for (int i = 0; i < NCHAN; i++) begin
         if ((rd_chan && rd_idx == CHW'(i)) || (rd_last && last_chan == CHW'(i))) begin
            clr_mask[i] = 1'b1;
         end
      end
      next_done = done & ~clr_mask;
      next_ovr = rd_stat ? '0 : ovr;
      if (eoc_ok) begin
         next_done[conv_i.chan] = 1'b1;
         if (done[conv_i.chan]) begin
            next_ovr[conv_i.chan] = 1'b1;
         end
      end
      next_data_ready_flag = eoc_ok || (data_ready_flag && !rd_last);
      next_global_overrun_flag = global_overrun_flag_evt || (global_overrun_flag && !rd_stat);
      next_last_data = eoc_ok ? conv_i.data : last_data;
      next_last_chan = eoc_ok ? conv_i.chan : last_chan;
   end

   // Mode, start command and low-power state.
   always_comb begin
      next_sleep_mode = wr_mode ? wr.data[MODE_SLEEP] : sleep_mode;
      next_start = wr_ctrl && wr.data[CTRL_START];
      next_sleep = sleep_o;
      if (!next_sleep_mode || next_start) begin
         next_sleep = 1'b0;
      end
      if (conv_i.valid && sleep_mode) begin
         next_sleep = 1'b1;
      end
   end

   // Interrupt status: events set, write-one clears, set wins.
   always_comb begin
      irq_evt = '0;
      irq_evt[IRQ_STORE] = eoc_ok;
      irq_evt[IRQ_OVR] = ovr_evt || global_overrun_flag_evt;
      irq_evt[IRQ_SLEEP] = next_sleep && !sleep_o;
      next_isr = (isr & ~(wr_isr ? wr.data[IRQW-1:0] : '0)) | irq_evt;
      next_imr = wr_imr ? wr.data[IRQW-1:0] : imr;
   end

   // Read data are captured before the clearing side effects land.
   always_comb begin
      next_rd_reg = '0;
      next_rd_err = 1'b0;
      next_rd_chan = rd_chan;
      case (rd.addr)
         OFS_MODE: next_rd_reg[MODE_SLEEP] = sleep_mode;
         OFS_CHSR: next_rd_reg[NCHAN-1:0] = chan_en;
         OFS_STAT: begin
            next_rd_reg[STAT_DONE_LSB +: NCHAN] = done;
            next_rd_reg[STAT_OVR_LSB +: NCHAN] = ovr;
            next_rd_reg[STAT_DATA_READY_FLAG] = data_ready_flag;
            next_rd_reg[STAT_GLOBAL_OVERRUN_FLAG] = global_overrun_flag;
         end
         OFS_LAST: begin
            next_rd_reg[RESW-1:0] = last_data;
            next_rd_reg[LAST_CHAN_LSB +: CHW] = last_chan;
         end
         OFS_ISR: next_rd_reg[IRQW-1:0] = isr;
         OFS_IMR: next_rd_reg[IRQW-1:0] = imr;
         default: next_rd_err = !rd_chan;
      endcase
      if (!rd.valid) begin
         next_rd_reg = rd_reg_q;
         next_rd_err = rd_err_q;
         next_rd_chan = rd_chan_q;
      end
   end

   assign rd_data = rd_chan_q ? {{(DW-RESW){1'b0}}, mem_q} : rd_reg_q;
   assign irq_o = |(isr & imr);

   // State registers.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         chan_en <= CHEN_RST;
         done <= '0;
         ovr <= '0;
         data_ready_flag <= 1'b0;
         global_overrun_flag <= 1'b0;
         last_data <= '0;
         last_chan <= '0;
         sleep_mode <= 1'b0;
         sleep_o <= 1'b0;
         start_o <= 1'b0;
         isr <= '0;
         imr <= IMR_RST;
         rd_reg_q <= '0;
         rd_err_q <= 1'b0;
         rd_chan_q <= 1'b0;
         lane0 <= 1'b0;
      end else begin
         chan_en <= next_chan_en;
         done <= next_done;
         ovr <= next_ovr;
         data_ready_flag <= next_data_ready_flag;
         global_overrun_flag <= next_global_overrun_flag;
         last_data <= next_last_data;
         last_chan <= next_last_chan;
         sleep_mode <= next_sleep_mode;
         sleep_o <= next_sleep;
         start_o <= next_start;
         isr <= next_isr;
         imr <= next_imr;
         rd_reg_q <= next_rd_reg;
         rd_err_q <= next_rd_err;
         rd_chan_q <= next_rd_chan;
         lane0 <= next_lane0;
      end
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   // Data-ready falls after a last-result read unless a new result lands.
   a_data_ready_flag_last_clear: assert property (
      rd_last && !eoc_ok |=> !data_ready_flag) else $error("data ready not cleared by last read");

   // A channel result read leaves data-ready standing.
   a_data_ready_flag_chan_keep: assert property (
      data_ready_flag && rd_chan |=> data_ready_flag) else $error("data ready lost on channel read");

   // Reading one channel clears its done flag and no other.
   a_done_own_clear: assert property (
      rd_chan && !(eoc_ok && conv_i.chan == rd_idx) |=> !done[$past(rd_idx)]
         && (($past(done) & ~done & ~(NCHAN'(1) << $past(rd_idx))) == '0))
      else $error("channel read cleared the wrong done flag");

   // An accepted result is stored as last result and raises data-ready.
   a_store_sets: assert property (
      eoc_ok |=> data_ready_flag && last_data == $past(conv_i.data)
         && done[last_chan] ##1 1'b1) else $error("accepted result not stored");

   // A result arriving under data-ready raises global overrun despite reads.
   a_global_overrun_flag_set: assert property (
      global_overrun_flag_evt |=> global_overrun_flag) else $error("global overrun missed");

   // A status read without a new overrun leaves global overrun low.
   a_global_overrun_flag_read: assert property (
      rd_stat && !global_overrun_flag_evt |=> !global_overrun_flag) else $error("global overrun not cleared");

   // A channel completing with done still set shows its overrun.
   a_chan_ovr: assert property (
      ovr_evt |=> ovr[$past(conv_i.chan)]) else $error("channel overrun missed");

   // A status read without a fresh overrun empties every channel overrun.
   a_ovr_read: assert property (
      rd_stat && !ovr_evt |=> ovr == '0) else $error("channel overrun not reset");

   // A refused result changes neither the done flag nor data-ready.
   a_refused_quiet: assert property (
      conv_i.valid && (!chan_en[conv_i.chan] || dis_mask[conv_i.chan])
         && !data_ready_flag && !done[conv_i.chan]
         |=> !data_ready_flag && !done[$past(conv_i.chan)]) else $error("refused result raised a flag");

   // Sleep waits for a completed conversion, then follows within one cycle.
   a_sleep_wait: assert property (
      !sleep_o && !conv_i.valid |=> !sleep_o) else $error("sleep entered without conversion");
endmodule
`default_nettype wire

// >>> dv/adc_result_status_flags_tb.sv
`timescale 1ns/100ps
`default_nettype none
module adc_result_status_flags_tb;
   import adc_flags_pkg::*;
   logic ref_clk_i, rst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
   logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, start_o, sleep_o, irq_o;
   logic [AW-1:0] awaddr_i, araddr_i;
   logic [DW-1:0] wdata_i, rdata_o;
   logic [3:0] wstrb_i;
   logic [1:0] bresp_o, rresp_o;
   conv_evt_t conv_i, cz, cv;
   int n_fail = 0;
   int cmp_count = 0;
   int n_start = 0;
   int x_start, i;
   // Bench copy of the flag and register state.
   logic [NCHAN-1:0] en, done, ovr;
   logic data_ready_flag, global_overrun_flag, mode, slp;
   logic [CHW-1:0] lch;
   logic [RESW-1:0] ld;
   logic [RESW-1:0] res [NCHAN];
   logic [IRQW-1:0] isr, imr;

   adc_result_status_flags u_dut (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i),
      .awready_o(awready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i),
      .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
      .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o), .rdata_o(rdata_o),
      .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i), .conv_i(conv_i),
      .start_o(start_o), .sleep_o(sleep_o), .irq_o(irq_o)
   );

   // Free-running 40 MHz clock.
   initial begin
      ref_clk_i = 1'h0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end

   // Counts start pulses, since each one stands for a single cycle.
   always @(posedge ref_clk_i) begin
      if (start_o === 1'h1) n_start <= n_start + 1;
   end

   task automatic wrap_up();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk_w(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic chk_b(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s exp %b got %b", nm, e, g);
      end
   endtask

   // A wait that ran out of its bound ends the run as a failure.
   task automatic tmo(input int k);
      if (k >= 50) begin
         n_fail++;
         wrap_up();
      end
   endtask

   function automatic conv_evt_t ev(input int c, input int d);
      conv_evt_t r;
      r.valid = 1'h1;
      r.chan = c[CHW-1:0];
      r.data = d[RESW-1:0];
      return r;
   endfunction

   function automatic logic [AW-1:0] pick(input int s, input int c);
      case (s)
         0: return OFS_STAT;
         1: return OFS_LAST;
         2: return OFS_CHSR;
         3: return OFS_ISR;
         default: return OFS_CDR0 + AW'(4 * c);
      endcase
   endfunction

   // Expected response and data of a read, before its own clearing effect.
   function automatic logic [33:0] exp_rd(input logic [AW-1:0] a);
      if (a >= OFS_CDR0 && a < OFS_CDR_END) return {RESP_OKAY, 22'h0, res[a[4:2]]};
      case (a)
         OFS_STAT: return {RESP_OKAY, 14'h0, global_overrun_flag, data_ready_flag, ovr, done};
         OFS_LAST: return {RESP_OKAY, 17'h0, lch, 2'h0, ld};
         OFS_CHSR: return {RESP_OKAY, 24'h0, en};
         OFS_MODE: return {RESP_OKAY, 31'h0, mode};
         OFS_ISR: return {RESP_OKAY, 29'h0, isr};
         OFS_IMR: return {RESP_OKAY, 29'h0, imr};
         default: return {RESP_SLVERR, 32'h0};
      endcase
   endfunction

   // One clock of flag updates: clears from a read, then sets, which win.
   function automatic void mdl(input conv_evt_t c, input logic [AW-1:0] ra,
                               input logic [NCHAN-1:0] dis);
      logic [NCHAN-1:0] nd, no;
      logic ndr, ngv, acc;
      nd = done;
      no = ovr;
      ndr = data_ready_flag;
      ngv = global_overrun_flag;
      acc = c.valid && en[c.chan] && !dis[c.chan];
      if (ra == OFS_LAST) begin
         nd[lch] = 1'h0;
         ndr = 1'h0;
      end
      if (ra == OFS_STAT) begin
         no = '0;
         ngv = 1'h0;
      end
      if (ra >= OFS_CDR0 && ra < OFS_CDR_END) nd[ra[4:2]] = 1'h0;
      if (acc) begin
         no[c.chan] = no[c.chan] | done[c.chan];
         ngv = ngv | data_ready_flag;
         isr[IRQ_OVR] = isr[IRQ_OVR] | done[c.chan] | data_ready_flag;
         isr[IRQ_STORE] = 1'h1;
         nd[c.chan] = 1'h1;
         ndr = 1'h1;
         res[c.chan] = c.data;
         lch = c.chan;
         ld = c.data;
      end
      if (c.valid && mode) begin
         isr[IRQ_SLEEP] = isr[IRQ_SLEEP] | !slp;
         slp = 1'h1;
      end
      done = nd;
      ovr = no;
      data_ready_flag = ndr;
      global_overrun_flag = ngv;
      en = en & ~dis;
   endfunction

   task automatic outs();
      chk_b("irq_o", |(isr & imr), irq_o);
      chk_b("sleep_o", slp, sleep_o);
      chk_w("starts", x_start, n_start);
   endtask

   task automatic cvt(input conv_evt_t c);
      conv_i <= c;
      @(posedge ref_clk_i);
      conv_i <= cz;
      mdl(c, 8'hFF, '0);
      repeat (2) @(posedge ref_clk_i);
      outs();
   endtask

   // Read with an optional end of conversion at the address handshake edge.
   task automatic rd(input logic [AW-1:0] a, input conv_evt_t c);
      logic [33:0] e;
      logic [31:0] d;
      logic [1:0] r;
      int k;
      e = exp_rd(a);
      araddr_i <= a;
      arvalid_i <= 1'h1;
      rready_i <= 1'h1;
      conv_i <= c;
      k = 0;
      do begin
         @(posedge ref_clk_i);
         conv_i <= cz;
         k++;
      end while (!arready_o && k < 50);
      arvalid_i <= 1'h0;
      do begin
         @(posedge ref_clk_i);
         k++;
      end while (!rvalid_o && k < 50);
      tmo(k);
      d = rdata_o;
      r = rresp_o;
      rready_i <= 1'h0;
      mdl(c, a, '0);
      chk_w("rresp", {30'h0, e[33:32]}, {30'h0, r});
      chk_w("rdata", e[31:0], d);
      @(posedge ref_clk_i);
      outs();
   endtask

   // Write with an optional end of conversion in the cycle the register acts.
   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d, input conv_evt_t c);
      logic aw, w;
      logic [1:0] ex;
      int k;
      awaddr_i <= a;
      awvalid_i <= 1'h1;
      wdata_i <= d;
      wvalid_i <= 1'h1;
      bready_i <= 1'h1;
      aw = 1'h0;
      w = 1'h0;
      k = 0;
      do begin
         @(posedge ref_clk_i);
         k++;
         if (awready_o && !aw) begin
            aw = 1'h1;
            awvalid_i <= 1'h0;
         end
         if (wready_o && !w) begin
            w = 1'h1;
            wvalid_i <= 1'h0;
         end
      end while (!(aw && w) && k < 50);
      conv_i <= c;
      do begin
         @(posedge ref_clk_i);
         conv_i <= cz;
         k++;
      end while (!bvalid_o && k < 50);
      tmo(k);
      ex = RESP_SLVERR;
      if (a inside {OFS_CTRL, OFS_MODE, OFS_CHEN, OFS_CHDIS, OFS_ISR, OFS_IMR}) ex = RESP_OKAY;
      chk_w("bresp", {30'h0, ex}, {30'h0, bresp_o});
      bready_i <= 1'h0;
      if (wstrb_i[0] && ex == RESP_OKAY) begin
         case (a)
            OFS_CTRL: begin
               x_start += d[0];
               slp = slp & !d[0];
            end
            OFS_MODE: begin
               mode = d[0];
               slp = slp & d[0];
            end
            OFS_CHEN: en = en | d[NCHAN-1:0];
            OFS_ISR: isr = isr & ~d[IRQW-1:0];
            OFS_IMR: imr = d[IRQW-1:0];
            default: ;
         endcase
      end
      mdl(c, 8'hFF, (a == OFS_CHDIS && wstrb_i[0]) ? d[NCHAN-1:0] : '0);
      @(posedge ref_clk_i);
      outs();
   endtask

   // Main sequence: reset, corner cases, then random traffic.
   initial begin
      cz = '0;
      conv_i = '0;
      rst_i = 1'h1;
      {awaddr_i, araddr_i, wdata_i} = '0;
      {awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = '0;
      wstrb_i = 4'hF;
      {en, done, ovr, data_ready_flag, global_overrun_flag, mode, slp, lch, ld, isr, imr} = '0;
      x_start = 0;
      foreach (res[j]) res[j] = '0;
      void'($urandom(36));
      repeat (20) @(posedge ref_clk_i);
      rst_i <= 1'h0;
      @(posedge ref_clk_i);
      rd(OFS_CHSR, cz);
      rd(OFS_IMR, cz);
      rd(OFS_STAT, cz);
      rd(8'h30, cz);
      wr(8'h30, 32'hFFFFFFFF, cz);
      wr(OFS_CHEN, 32'hFF, cz);
      cvt(ev(5, 11));
      cvt(ev(4, 22));
      rd(OFS_CDR0 + 8'h14, ev(6, 33));
      rd(OFS_STAT, cz);
      rd(OFS_CDR0 + 8'h10, cz);
      rd(OFS_STAT, cz);
      rd(OFS_LAST, cz);
      rd(OFS_STAT, cz);
      cvt(ev(1, 44));
      rd(OFS_CDR0 + 8'h08, ev(1, 55));
      rd(OFS_STAT, cz);
      rd(OFS_STAT, ev(2, 66));
      rd(OFS_STAT, cz);
      cvt(ev(7, 1));
      cvt(ev(7, 2));
      rd(OFS_CDR0 + 8'h1C, cz);
      rd(OFS_LAST, cz);
      rd(OFS_STAT, ev(7, 3));
      rd(OFS_STAT, cz);
      rd(OFS_LAST, cz);
      wr(OFS_CHDIS, 32'h1, ev(7, 4));
      rd(OFS_STAT, cz);
      wr(OFS_CHDIS, 32'h2, ev(7, 5));
      rd(OFS_CDR0 + 8'h1C, cz);
      rd(OFS_STAT, cz);
      rd(OFS_LAST, cz);
      wr(OFS_CHDIS, 32'h4, cz);
      rd(OFS_CDR0, ev(2, 77));
      cvt(ev(3, 88));
      rd(OFS_LAST, ev(2, 99));
      wr(OFS_CHDIS, 32'h8, ev(3, 9));
      rd(OFS_STAT, cz);
      rd(OFS_CHSR, cz);
      wr(OFS_CHEN, 32'hFF, cz);
      wr(OFS_MODE, 32'h1, cz);
      rd(OFS_MODE, cz);
      wr(OFS_CTRL, 32'h1, cz);
      cvt(ev(0, 5));
      wr(OFS_MODE, 32'h0, cz);
      rd(OFS_ISR, cz);
      wr(OFS_IMR, 32'h7, cz);
      wr(OFS_ISR, 32'h7, cz);
      cvt(ev(5, 6));
      wr(OFS_IMR, 32'h2, cz);
      wstrb_i <= 4'h0;
      wr(OFS_IMR, 32'h0, cz);
      wstrb_i <= 4'hF;
      rd(OFS_IMR, cz);
      for (i = 0; i < 300; i++) begin
         cv = ev($urandom_range(7), $urandom);
         case ($urandom_range(3))
            0: cvt(cv);
            1: rd(pick($urandom_range(4), $urandom_range(7)), $urandom_range(1) ? cv : cz);
            2: wr(OFS_CHDIS, 32'h1 << $urandom_range(7), cv);
            default: wr(OFS_CHEN, $urandom, cz);
         endcase
      end
      wrap_up();
   end
endmodule
`default_nettype wire
